// File: tb/dmc_host_model.sv
// Host model driving the three-wire control port of the mode-control block
module dmc_host_model (
  // Clock
  input wire logic clk_sys,
  // Control port pins
  output logic sdata,
  output logic sclk,
  output logic sel_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port: select high, clock parked low
  initial begin
    sdata = 1'b0;
    sclk = 1'b0;
    sel_n = 1'b1;
  end

  // One clock level lasts 4 system cycles, an 80 ns link period
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask

  // Frame of nbits, MSB first, taken on rising control clock edges
  task automatic frame(input logic [23:0] bits, input int nbits);
    sel_n = 1'b0;
    half();
    for (int i = nbits - 1; i >= 0; i--) begin
      sdata = bits[i];
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    sel_n = 1'b1;
    sdata = ~sdata; // Released line carries no stale bit
    repeat (8) half();
  endtask
endmodule // dmc_host_model

// File: tb/dmc_top_tb_top.sv
// Self-checking bench of the mode-control, zero flag and mute block
module dmc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst, s_hi, s_lo, mute_n, halt, dis, psave, tick, w32, inv;
  logic [1:0] comb;
  logic [3:0] nzl, nzr;
  logic sdata, sclk, sel_n, p20o, p20e, p23o, p23e, mso, mse, fa, fb;
  logic centre, pd, deemph, tdm, wstb;
  logic [1:0] mode;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [14:0] wq[$];
  logic [6:0] rows[6] = '{7'h48, 7'h6f, 7'h5e, 7'h41, 7'h02, 7'h2e};
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  dmc_host_model u_host (.clk_sys(clk_sys), .sdata(sdata), .sclk(sclk), .sel_n(sel_n));

  dmc_top u_dut (.clk_sys(clk_sys), .rst(rst), .mode_sense_hi(s_hi), .mode_sense_lo(s_lo),
    .pin20_in(sdata), .pin20_out(p20o), .pin20_oe(p20e), .pin21_in(sclk), .pin22_in(sel_n),
    .pin23_in(1'b0), .pin23_out(p23o), .pin23_oe(p23e), .mute_in_n(mute_n),
    .mute_status_n_out(mso), .mute_status_n_oe(mse), .clk_halt_det(halt), .async_det(1'b0),
    .zero_mute_en(1'b0), .converter_disable_bit(dis), .power_save_bit(psave),
    .sample_tick(tick), .nz_left(nzl), .nz_right(nzr), .word_32bit(w32), .zero_comb(comb),
    .zero_pol_inv(inv), .zero_flag_a(fa), .zero_flag_b(fb), .dac_centre(centre),
    .dac_power_down(pd), .deemph_en(deemph), .fmt_tdm(tdm), .mode_sel(mode),
    .wr_strobe(wstb), .wr_addr(waddr), .wr_data(wdata));

  // Collect register writes
  always @(posedge clk_sys) begin
    if (wstb === 1'b1) begin
      wq.push_back({waddr, wdata});
    end
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reset for 3 cycles with the strap set, checking reset levels
  task automatic do_reset(input logic hi);
    @(negedge clk_sys);
    rst = 1'b1;
    s_hi = hi;
    repeat (3) @(negedge clk_sys);
    chk({centre, pd, mse, wstb, fa, fb}, 16'h0020, "reset levels");
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
  endtask

  // Sample ticks, two cycles each, then one settling cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      tick = 1'b1;
      @(negedge clk_sys);
      tick = 1'b0;
    end
    @(negedge clk_sys);
  endtask

  // Main sequence
  initial begin
    {rst, s_hi, s_lo, halt, dis, tick, w32, inv, comb, nzl, nzr} = '0;
    {mute_n, psave} = 2'b11;
    do_reset(1'b1);
    chk(mode, 16'h0002, "three-wire strap");
    // Ordinary mute cases: inputs beside expected mute, centre, power-down
    foreach (rows[i]) begin
      {mute_n, dis, halt, psave} = rows[i][6:3];
      repeat (4) @(negedge clk_sys);
      chk({mse, centre, pd}, rows[i][2:0], "mute row");
    end
    {mute_n, dis, psave} = 3'b101;
    $display("test mute rows done");
    ticks(1023);
    chk({fa, fb}, 16'h0000, "flags early");
    ticks(1);
    chk({fa, fb}, 16'h0003, "flags set");
    inv = 1'b1;
    @(negedge clk_sys);
    chk({fa, fb}, 16'h0000, "inverted");
    inv = 1'b0;
    nzr = 4'h1;
    @(negedge clk_sys);
    chk({fa, fb}, 16'h0002, "right drop");
    comb = 2'b11;
    @(negedge clk_sys);
    chk(fa, 16'h0000, "comb d drop");
    nzr = 4'h0;
    w32 = 1'b1;
    ticks(1100);
    chk({fa, fb}, 16'h0000, "32-bit words");
    w32 = 1'b0;
    $display("test zero flags done");
    u_host.frame(24'h45a53c, 24);
    u_host.frame(24'h00c5a5, 16);
    u_host.frame(24'h004f11, 16);
    chk(16'(wq.size()), 16'h0003, "write count");
    chk(16'(wq[0]), 16'h45a5, "first word");
    chk(16'(wq[1]), 16'h463c, "burst byte");
    chk(16'(wq[2]), 16'h4f11, "single word");
    $display("test three-wire done");
    do_reset(1'b0);
    chk(mode, 16'h0001, "open strap");
    s_hi = 1'b1;
    u_host.sdata = 1'b1;
    u_host.sclk = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({mode, deemph, tdm}, 16'h0007, "parallel high");
    u_host.sdata = 1'b0;
    u_host.sclk = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({deemph, tdm}, 16'h0000, "parallel low");
    $display("test parallel done");
    s_lo = 1'b1;
    do_reset(1'b0);
    chk(mode, 16'h0000, "low strap");
    $display("test two-wire strap done");
    print_verdict();
  end
endmodule // dmc_top_tb_top

// File: verilog/dmc_pkg.sv
// Shared constants, types and helper functions of the converter mode-control block
package dmc_pkg;

  // ---------------------------------------------------------------
  // Zero detection
  // ---------------------------------------------------------------
  localparam logic [10:0] ZERO_SAMPLES = 11'h400; // Sample periods of all-zero data
  localparam logic [10:0] ZERO_CNT_RST = 11'h000;

  // Channel masks, bit i = left of channel i+1, bit 4+i = right of channel i+1
  localparam logic [7:0] MASK_A_FLAG1 = 8'h01;
  localparam logic [7:0] MASK_A_FLAG2 = 8'h10;
  localparam logic [7:0] MASK_B_FLAGS = 8'hff;
  localparam logic [7:0] MASK_C_FLAG1 = 8'h88;
  localparam logic [7:0] MASK_C_FLAG2 = 8'h77;
  localparam logic [7:0] MASK_D_FLAG1 = 8'h11;
  localparam logic [7:0] MASK_D_FLAG2 = 8'hee;

  // ---------------------------------------------------------------
  // Control ports
  // ---------------------------------------------------------------
  localparam logic [6:0] REG_BASE = 7'h40; // Lowest defined register
  localparam logic [6:0] REG_TOP = 7'h4f; // Highest defined register
  localparam logic [3:0] W3_FIRST_LAST = 4'hf; // Index of last bit of the 16-bit word
  localparam logic [3:0] W3_NEXT_LAST = 4'h7; // Index of last bit of a burst byte
  localparam logic [2:0] I2C_BYTE_LAST = 3'h7; // Index of last bit of a byte

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_I2C = 2'b00,
    MODE_PAR = 2'b01,
    MODE_W3 = 2'b10
  } dmc_mode_e;

  typedef enum logic [1:0] {
    COMB_A = 2'b00,
    COMB_B = 2'b01,
    COMB_C = 2'b10,
    COMB_D = 2'b11
  } dmc_comb_e;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_REG = 3'b010,
    I2C_DATA = 3'b011,
    I2C_ACK = 3'b100,
    I2C_SKIP = 3'b101
  } dmc_i2c_e;

  // ---------------------------------------------------------------
  // State records
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sclk_q;
    logic sel_q;
    logic [3:0] nbits;
    logic first;
    logic bad;
    logic [15:0] sh;
    logic pend;
    logic [6:0] paddr;
    logic [7:0] pdata;
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } dmc_w3_s;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [1:0] m1;
    logic [1:0] m2;
    logic mode_ok;
    dmc_mode_e mode;
    logic [10:0] cnt_a;
    logic [10:0] cnt_b;
    logic fa;
    logic fb;
    logic za;
    logic zb;
    logic centre;
    logic pd;
    logic ms_oe;
    logic tst;
    logic deemph;
    logic tdm;
    logic scl_q;
    logic sda_q;
    dmc_i2c_e ist;
    dmc_i2c_e after;
    logic [2:0] bcnt;
    logic bdone;
    logic [7:0] sh;
    logic [6:0] idx;
    logic sda_oe;
    logic wr;
    logic [6:0] wa;
    logic [7:0] wd;
  } dmc_top_s;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Channels watched by one flag under a given assignment
  function automatic logic [7:0] chan_mask(input dmc_comb_e comb, input logic second);
    case (comb)
      COMB_A: chan_mask = second ? MASK_A_FLAG2 : MASK_A_FLAG1;
      COMB_B: chan_mask = MASK_B_FLAGS;
      COMB_C: chan_mask = second ? MASK_C_FLAG2 : MASK_C_FLAG1;
      COMB_D: chan_mask = second ? MASK_D_FLAG2 : MASK_D_FLAG1;
      default: chan_mask = MASK_B_FLAGS;
    endcase
  endfunction

  // Zero-run counter step, saturating at the detection count
  function automatic logic [10:0] zero_step(input logic [10:0] cnt, input logic tick,
                                            input logic nz, input logic w32);
    if (nz || w32) begin
      zero_step = ZERO_CNT_RST;
    end else if (tick && (cnt != ZERO_SAMPLES)) begin
      zero_step = cnt + 11'h001;
    end else begin
      zero_step = cnt;
    end
  endfunction

  // Register address is one of the defined registers
  function automatic logic reg_ok(input logic [6:0] a);
    reg_ok = (a >= REG_BASE) && (a <= REG_TOP);
  endfunction

  // Next register index of a burst, wrapping top to base
  function automatic logic [6:0] next_idx(input logic [6:0] a);
    next_idx = (a == REG_TOP) ? REG_BASE : 7'(a + 7'h01);
  endfunction

endpackage

// File: verilog/dmc_top.sv
// Mode control, zero flags and analog mute logic of the eight-channel converter
// How it works
// - Flag asserts after its channels stay all zero for 1024 sample periods.
// - Any nonzero bit on an assigned channel drops the flag at once.
// - Zero detection runs for 16/20/24-bit words, never for 32-bit words.
// - Flag polarity is invertible; reset default is active high.
// - Four selectable channel assignments for the two flags.
// - Parallel hardware mode forces assignment A.
// - Mute input low forces converter outputs to centre level.
// - Open-drain mute status goes low whenever internal mute is active.
// - Mute input low overrides and ignores power-down settings.
// - Three-state strap picks two-wire, parallel or three-wire control.
// - Strap is captured only at reset release; later changes ignored.
// - Mode remaps four shared pins to their interface roles.
// - Parallel mode: de-emphasis pin high enables de-emphasis on all channels.
// - Parallel mode: format pin low selects plain I2S, high selects TDM.
// - Three-wire port is sampled by the system clock; control clock edges are found on synchronised pins.
// - Three-wire word is zero write bit, 7-bit address, 8 data bits.
// - Select low, 16 clocks, select high latches the word.
// - Further 8-clock groups write following registers until select rises.
// - Two-wire port acts only as a slave.
// - Slave address is five fixed bits plus two address pins.
// - Two-wire burst index increments per byte, wrapping top to base.
// - Undefined register addresses are not acknowledged.
module dmc_top #(
  parameter logic [4:0] BUS_ADDR_HI = 5'h0a // Arbitrary fixed upper address bits
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Mode strap sensing
  input wire logic mode_sense_hi,
  input wire logic mode_sense_lo,
  // Shared control pins
  input wire logic pin20_in,
  output logic pin20_out,
  output logic pin20_oe,
  input wire logic pin21_in,
  input wire logic pin22_in,
  input wire logic pin23_in,
  output logic pin23_out,
  output logic pin23_oe,
  // Analog mute
  input wire logic mute_in_n,
  output logic mute_status_n_out,
  output logic mute_status_n_oe,
  input wire logic clk_halt_det,
  input wire logic async_det,
  input wire logic zero_mute_en,
  input wire logic converter_disable_bit,
  input wire logic power_save_bit,
  // Zero detection inputs and settings
  input wire logic sample_tick,
  input wire logic [3:0] nz_left,
  input wire logic [3:0] nz_right,
  input wire logic word_32bit,
  input wire logic [1:0] zero_comb,
  input wire logic zero_pol_inv,
  // Flag and converter outputs
  output logic zero_flag_a,
  output logic zero_flag_b,
  output logic dac_centre,
  output logic dac_power_down,
  output logic deemph_en,
  output logic fmt_tdm,
  output logic [1:0] mode_sel,
  // Register writes
  output logic wr_strobe,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data
);

  dmc_pkg::dmc_top_s r_reg;
  dmc_pkg::dmc_top_s r_next;
  dmc_wr_if w3_if();
  dmc_pkg::dmc_comb_e comb;
  logic [7:0] nz;
  logic nz_a;
  logic nz_b;
  logic mute_hi;
  logic int_mute;
  logic sda;
  logic scl;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic ack_ok;

  // ---------------------------------------------------------------
  // Three-wire receiver
  // ---------------------------------------------------------------
  dmc_wire3 u_wire3 (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(r_reg.mode_ok && (r_reg.mode == dmc_pkg::MODE_W3)),
    .sclk(r_reg.s2[1]),
    .sdata(r_reg.s2[0]),
    .sel_n(r_reg.s2[2]),
    .wr(w3_if.src)
  );

  // ---------------------------------------------------------------
  // Synchronised pin views and derived terms
  // ---------------------------------------------------------------
  assign sda = r_reg.s2[0];
  assign scl = r_reg.s2[1];
  assign mute_hi = r_reg.s2[4];
  assign start_c = scl && r_reg.scl_q && r_reg.sda_q && !sda;
  assign stop_c = scl && r_reg.scl_q && !r_reg.sda_q && sda;
  assign scl_rise = scl && !r_reg.scl_q;
  assign scl_fall = !scl && r_reg.scl_q;
  assign comb = (r_reg.mode == dmc_pkg::MODE_PAR) ? dmc_pkg::COMB_A :
                dmc_pkg::dmc_comb_e'(zero_comb);
  assign nz = {nz_right, nz_left};
  assign nz_a = |(nz & dmc_pkg::chan_mask(comb, 1'b0));
  assign nz_b = |(nz & dmc_pkg::chan_mask(comb, 1'b1));
  assign int_mute = clk_halt_det || async_det || converter_disable_bit ||
                    (zero_mute_en && (r_reg.fa || r_reg.fb));

  // Ack decision for the byte just completed on the two-wire bus
  always_comb begin
    ack_ok = 1'b0;
    case (r_reg.ist)
      dmc_pkg::I2C_ADDR: ack_ok = (r_reg.sh == {BUS_ADDR_HI, r_reg.s2[3], r_reg.s2[2], 1'b0});
      dmc_pkg::I2C_REG: ack_ok = dmc_pkg::reg_ok(r_reg.sh[6:0]);
      dmc_pkg::I2C_DATA: ack_ok = 1'b1;
      default: ack_ok = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    r_next = r_reg;
    r_next.s1 = {mute_in_n, pin23_in, pin22_in, pin21_in, pin20_in};
    r_next.s2 = r_reg.s1;
    r_next.m1 = {mode_sense_hi, mode_sense_lo};
    r_next.m2 = r_reg.m1;
    r_next.scl_q = scl;
    r_next.sda_q = sda;
    r_next.wr = 1'b0;
    r_next.tst = 1'b0;
    // Strap capture once after reset release
    if (!r_reg.mode_ok) begin
      r_next.mode_ok = 1'b1;
      if (r_reg.m2 == 2'b10) begin
        r_next.mode = dmc_pkg::MODE_W3;
      end else if (r_reg.m2 == 2'b01) begin
        r_next.mode = dmc_pkg::MODE_I2C;
      end else begin
        r_next.mode = dmc_pkg::MODE_PAR;
      end
    end
    // Zero-run counters and flags
    r_next.cnt_a = dmc_pkg::zero_step(r_reg.cnt_a, sample_tick, nz_a, word_32bit);
    r_next.cnt_b = dmc_pkg::zero_step(r_reg.cnt_b, sample_tick, nz_b, word_32bit);
    r_next.fa = (r_next.cnt_a == dmc_pkg::ZERO_SAMPLES);
    r_next.fb = (r_next.cnt_b == dmc_pkg::ZERO_SAMPLES);
    r_next.za = r_next.fa ^ zero_pol_inv;
    r_next.zb = r_next.fb ^ zero_pol_inv;
    // Mute and power-down; mute input wins over power-down
    r_next.centre = !mute_hi || int_mute;
    r_next.pd = mute_hi && (converter_disable_bit || !power_save_bit);
    r_next.ms_oe = int_mute;
    // Parallel pin functions
    r_next.deemph = (r_reg.mode == dmc_pkg::MODE_PAR) && r_reg.s2[0];
    r_next.tdm = (r_reg.mode == dmc_pkg::MODE_PAR) && r_reg.s2[1];
    // Three-wire writes
    if (w3_if.valid) begin
      r_next.wr = 1'b1;
      r_next.wa = w3_if.addr;
      r_next.wd = w3_if.data;
    end
    // Two-wire slave receiver, never drives the clock
    if (!r_reg.mode_ok || (r_reg.mode != dmc_pkg::MODE_I2C)) begin
      r_next.ist = dmc_pkg::I2C_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (start_c) begin
      r_next.ist = dmc_pkg::I2C_ADDR;
      r_next.bcnt = 3'h0;
      r_next.bdone = 1'b0;
      r_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      r_next.ist = dmc_pkg::I2C_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.ist)
        dmc_pkg::I2C_ADDR, dmc_pkg::I2C_REG, dmc_pkg::I2C_DATA: begin
          if (scl_rise) begin
            r_next.sh = {r_reg.sh[6:0], sda};
            r_next.bcnt = r_reg.bcnt + 3'h1;
            r_next.bdone = (r_reg.bcnt == dmc_pkg::I2C_BYTE_LAST);
          end else if (scl_fall && r_reg.bdone) begin
            r_next.bdone = 1'b0;
            r_next.ist = ack_ok ? dmc_pkg::I2C_ACK : dmc_pkg::I2C_SKIP;
            r_next.sda_oe = ack_ok;
            if (r_reg.ist == dmc_pkg::I2C_ADDR) begin
              r_next.after = dmc_pkg::I2C_REG;
            end else if (r_reg.ist == dmc_pkg::I2C_REG) begin
              r_next.after = dmc_pkg::I2C_DATA;
              r_next.idx = r_reg.sh[6:0];
            end else begin
              r_next.after = dmc_pkg::I2C_DATA;
              r_next.wr = 1'b1;
              r_next.wa = r_reg.idx;
              r_next.wd = r_reg.sh;
              r_next.idx = dmc_pkg::next_idx(r_reg.idx);
            end
          end
        end
        dmc_pkg::I2C_ACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.ist = r_reg.after;
            r_next.bcnt = 3'h0;
          end
        end
        dmc_pkg::I2C_SKIP: r_next.sda_oe = 1'b0;
        default: r_next.ist = dmc_pkg::I2C_IDLE;
      endcase
    end
    if (rst) begin
      r_next.mode_ok = 1'b0;
      r_next.mode = dmc_pkg::MODE_PAR;
      r_next.cnt_a = dmc_pkg::ZERO_CNT_RST;
      r_next.cnt_b = dmc_pkg::ZERO_CNT_RST;
      r_next.fa = 1'b0;
      r_next.fb = 1'b0;
      r_next.za = 1'b0;
      r_next.zb = 1'b0;
      r_next.centre = 1'b1;
      r_next.pd = 1'b0;
      r_next.ms_oe = 1'b0;
      r_next.deemph = 1'b0;
      r_next.tdm = 1'b0;
      r_next.scl_q = 1'b1;
      r_next.sda_q = 1'b1;
      r_next.ist = dmc_pkg::I2C_IDLE;
      r_next.after = dmc_pkg::I2C_IDLE;
      r_next.bcnt = 3'h0;
      r_next.bdone = 1'b0;
      r_next.sh = 8'h00;
      r_next.idx = dmc_pkg::REG_BASE;
      r_next.sda_oe = 1'b0;
      r_next.wr = 1'b0;
      r_next.wa = 7'h00;
      r_next.wd = 8'h00;
    end
  end

  // State register; synchronisers run through reset
  always_ff @(posedge clk_sys) begin
    r_reg <= r_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pin20_out = r_reg.tst;
  assign pin20_oe = r_reg.sda_oe;
  assign pin23_out = r_reg.tst;
  assign pin23_oe = r_reg.tst;
  assign mute_status_n_out = r_reg.tst;
  assign mute_status_n_oe = r_reg.ms_oe;
  assign zero_flag_a = r_reg.za;
  assign zero_flag_b = r_reg.zb;
  assign dac_centre = r_reg.centre;
  assign dac_power_down = r_reg.pd;
  assign deemph_en = r_reg.deemph;
  assign fmt_tdm = r_reg.tdm;
  assign mode_sel = r_reg.mode;
  assign wr_strobe = r_reg.wr;
  assign wr_addr = r_reg.wa;
  assign wr_data = r_reg.wd;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_zero_set;
    !word_32bit && !nz_a && sample_tick && (r_reg.cnt_a == 11'h3ff) |=> r_reg.fa;
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("flag a not set at count");

  property p_zero_clear;
    nz_b |=> !r_reg.fb && (zero_flag_b == $past(zero_pol_inv));
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("flag b not cleared at once");

  property p_zero_w32;
    word_32bit [*2] |-> !r_reg.fa && !r_reg.fb;
  endproperty
  a_zero_w32: assert property (p_zero_w32) else $error("zero flag set with 32-bit words");

  property p_mute_centre;
    !mute_hi |=> dac_centre && !dac_power_down;
  endproperty
  a_mute_centre: assert property (p_mute_centre) else $error("mute input not obeyed");

  property p_mute_status;
    converter_disable_bit |=> mute_status_n_oe && !mute_status_n_out && dac_centre;
  endproperty
  a_mute_status: assert property (p_mute_status) else $error("mute status not driven low");

  property p_mode_hold;
    r_reg.mode_ok |=> r_reg.mode_ok && $stable(r_reg.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");

  property p_par_pins;
    (r_reg.mode == dmc_pkg::MODE_PAR) && r_reg.mode_ok |=> deemph_en == $past(r_reg.s2[0]);
  endproperty
  a_par_pins: assert property (p_par_pins) else $error("de-emphasis pin not followed");

  property p_idx_wrap;
    r_next.wr && (r_reg.ist == dmc_pkg::I2C_DATA) && (r_reg.idx == dmc_pkg::REG_TOP)
      |=> r_reg.idx == dmc_pkg::REG_BASE;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("burst index did not wrap");

  property p_no_ack_undef;
    scl_fall && r_reg.bdone && (r_reg.ist == dmc_pkg::I2C_REG) && !start_c && !stop_c &&
      !dmc_pkg::reg_ok(r_reg.sh[6:0]) && (r_reg.mode == dmc_pkg::MODE_I2C) |=> !pin20_oe;
  endproperty
  a_no_ack_undef: assert property (p_no_ack_undef) else $error("undefined register acked");

endmodule // dmc_top

// File: verilog/dmc_wire3.sv
// Three-wire write-only control port receiver, sampled by the system clock
module dmc_wire3 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Port enable and synchronised pin levels
  input wire logic enable,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sel_n,
  // Decoded register writes
  dmc_wr_if.src wr
);

  dmc_pkg::dmc_w3_s r_reg;
  dmc_pkg::dmc_w3_s r_next;
  logic sclk_rise;
  logic sel_rise;
  logic sel_fall;

  // ---------------------------------------------------------------
  // Edge detection on the control clock and select
  // ---------------------------------------------------------------
  assign sclk_rise = sclk && !r_reg.sclk_q && !sel_n;
  assign sel_rise = sel_n && !r_reg.sel_q;
  assign sel_fall = !sel_n && r_reg.sel_q;

  // Shift, word framing and burst handling
  always_comb begin
    r_next = r_reg;
    r_next.sclk_q = sclk;
    r_next.sel_q = sel_n;
    r_next.valid = 1'b0;
    if (!enable) begin
      r_next.pend = 1'b0;
      r_next.first = 1'b1;
      r_next.nbits = 4'h0;
    end else if (sel_fall) begin
      r_next.nbits = 4'h0;
      r_next.first = 1'b1;
      r_next.bad = 1'b0;
      r_next.pend = 1'b0;
    end else if (sel_rise) begin
      // Raising select latches the staged word
      r_next.valid = r_reg.pend;
      r_next.addr = r_reg.paddr;
      r_next.data = r_reg.pdata;
      r_next.pend = 1'b0;
    end else if (sclk_rise) begin
      r_next.sh = {r_reg.sh[14:0], sdata}; // MSB first
      r_next.nbits = r_reg.nbits + 4'h1;
      if (r_reg.first && (r_reg.nbits == 4'h0)) begin
        r_next.bad = sdata; // Leading bit must be a zero write bit
      end
      if (r_reg.first && (r_reg.nbits == dmc_pkg::W3_FIRST_LAST)) begin
        r_next.first = 1'b0;
        r_next.nbits = 4'h0;
        r_next.pend = !r_reg.bad;
        r_next.paddr = r_reg.sh[13:7]; // Bit 14 holds the write bit
        r_next.pdata = {r_reg.sh[6:0], sdata};
      end else if (!r_reg.first && (r_reg.nbits == dmc_pkg::W3_NEXT_LAST)) begin
        // Each further byte goes to the next register
        r_next.nbits = 4'h0;
        r_next.valid = r_reg.pend;
        r_next.addr = r_reg.paddr;
        r_next.data = r_reg.pdata;
        r_next.paddr = 7'(r_reg.paddr + 7'h01);
        r_next.pdata = {r_reg.sh[6:0], sdata};
      end
    end
    if (rst) begin
      r_next.nbits = 4'h0;
      r_next.first = 1'b1;
      r_next.bad = 1'b0;
      r_next.pend = 1'b0;
      r_next.valid = 1'b0;
      r_next.sel_q = 1'b1;
      r_next.sclk_q = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    r_reg <= r_next;
  end

  assign wr.valid = r_reg.valid;
  assign wr.addr = r_reg.addr;
  assign wr.data = r_reg.data;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_w3_latch;
    enable && sel_rise && r_reg.pend |=> r_reg.valid && (r_reg.addr == $past(r_reg.paddr));
  endproperty
  a_w3_latch: assert property (p_w3_latch) else $error("staged word not latched");

  property p_w3_badbit;
    r_reg.bad && r_reg.first |-> ##1 !r_reg.pend;
  endproperty
  a_w3_badbit: assert property (p_w3_badbit) else $error("word with write bit one staged");

endmodule // dmc_wire3

// File: verilog/dmc_wr_if.sv
// Register write carrier between the three-wire receiver and the top module
interface dmc_wr_if;
  logic valid;
  logic [6:0] addr;
  logic [7:0] data;

  modport src(output valid, output addr, output data);
  modport dst(input valid, input addr, input data);
endinterface
